// ==== design/dcs_chain_seq.v ====
// Purpose: chain transfer sequencer of an interrupt-triggered transfer controller
// Assumes: one clock ref_clk, async active-low rst_n, memory bus answers on ref_clk
// Notes: registers over AXI4-Lite; records are four words in memory
// Behaviour
// - on activation read the source vector slot, then the first record there
// - chain-enable set: after the transfer load and run the next record
// - keep chaining until a record with chain-enable clear or its chain-select condition unmet completes, then end
// - chain-select 0: chain after every transfer regardless of counter
// - chain-select 1: chain only when counter goes 1 to 0 or 1 to reload
// - legacy variant: chain-select 1 chains only when counter is zero after
// - chain-enable 1, chain-select 0, each-transfer irq 1: no irq on chaining, completion irq once the chain ends
// - vector slot located relative to programmed vector base
// - block mode: move a whole block, each address increments only if its increment mode bit is set
// - each transfer decrements transfer counter A by one, except a block end, which reloads it from its high byte
// - write the updated record back to memory after each transfer, in block mode only once the block ends
// - final record done with count zero, after chaining or each-transfer irq: clear activation enable, forward irq; else consume the source flag
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "dcs_consts.vh"
module dcs_chain_seq #(
  parameter NSRC = 4,
  parameter SRCW = 2
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [NSRC-1:0] act_req,
  output reg [NSRC-1:0] act_clr,
  output reg mem_req,
  output reg mem_we,
  output reg mem_byte,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  input wire [31:0] mem_rdata,
  input wire mem_ack,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg irq
);
  localparam S_IDLE = 3'd0;
  localparam S_VEC = 3'd1;
  localparam S_REC = 3'd2;
  localparam S_RD = 3'd3;
  localparam S_WR = 3'd4;
  localparam S_WB = 3'd5;
  localparam S_END = 3'd6;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        merge[k*8 +: 8] = be[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
      end
    end
  endfunction

  function [SRCW-1:0] lowest;
    input [NSRC-1:0] v;
    integer k;
    begin
      lowest = {SRCW{1'b0}};
      for (k = NSRC - 1; k >= 0; k = k - 1) begin
        if (v[k]) lowest = k[SRCW-1:0];
      end
    end
  endfunction

  // =====================================================
  // registers and request synchroniser
  reg [31:0] ctrl;
  reg [31:0] vbase;
  reg [NSRC-1:0] acten;
  reg [NSRC-1:0] istat;
  reg [NSRC-1:0] imask;
  reg [NSRC-1:0] req_s1;
  reg [NSRC-1:0] req_s2;
  reg [2:0] state;
  reg [SRCW-1:0] src;
  reg [31:0] rec_ptr;
  reg [1:0] widx;
  reg [7:0] mode;
  reg [31:0] sar;
  reg [31:0] dar;
  reg [15:0] transfer_counter_a;
  reg [15:0] crb;
  reg go_chain;
  reg cnt_done;
  reg chained;
  reg fin_raise;
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [NSRC-1:0] spent;

  // a consumed source stays masked until its synchronised request has fallen
  wire [NSRC-1:0] pend = req_s2 & acten & ~spent;
  wire [31:0] acten_wr = merge({{(32-NSRC){1'b0}}, acten}, w_data, w_strb);
  wire [31:0] imask_wr = merge({{(32-NSRC){1'b0}}, imask}, w_data, w_strb);
  wire [9:0] vec_num = `DCS_VEC_FIRST + {{(10-SRCW){1'b0}}, src};
  wire legacy = ctrl[`DCS_CTRL_LEGACY];
  wire blk = mode[`DCS_MB_BLOCK];
  wire blk_end = blk & (transfer_counter_a[7:0] == 8'h01);
  wire xfer_end = ~blk | blk_end;
  wire [15:0] next_cra = blk_end ? {transfer_counter_a[15:8], transfer_counter_a[15:8]} : transfer_counter_a - 16'h0001;
  wire [15:0] next_crb = blk_end ? crb - 16'h0001 : crb;
  wire was_one = blk ? blk_end : (transfer_counter_a == 16'h0001);
  wire zero_after = blk ? (next_crb == 16'h0000) : (next_cra == 16'h0000);
  wire sel_ok = legacy ? zero_after : was_one;
  wire next_chain = mode[`DCS_MB_CHAIN_EN] & (~mode[`DCS_MB_CHAIN_SEL] | sel_ok);
  wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
  wire [NSRC-1:0] end_clr = (state == S_END && fin_raise) ?
                            ({{(NSRC-1){1'b0}}, 1'b1} << src) : {NSRC{1'b0}};
  wire [NSRC-1:0] end_set = end_clr;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_s1 <= {NSRC{1'b0}};
      req_s2 <= {NSRC{1'b0}};
    end else begin
      req_s1 <= act_req;
      req_s2 <= req_s1;
    end
  end

  // =====================================================
  // AXI4-Lite slave
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `DCS_CTRL_RST;
      vbase <= `DCS_VBASE_RST;
      acten <= {NSRC{1'b0}};
      istat <= {NSRC{1'b0}};
      imask <= {NSRC{1'b0}};
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DCS_RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `DCS_RESP_OK;
      s_axi_rdata <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      // hardware set beats a software write-one-to-clear in the same cycle
      istat <= istat | end_set;
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `DCS_RESP_OK;
        case (aw_addr)
          `DCS_OFF_CTRL: ctrl <= merge(ctrl, w_data, w_strb) & 32'h00000003;
          `DCS_OFF_VBASE: vbase <= merge(vbase, w_data, w_strb);
          `DCS_OFF_ACTEN: acten <= acten_wr[NSRC-1:0] & ~end_clr;
          `DCS_OFF_ISTAT: istat <= (istat & ~(w_data[NSRC-1:0] &
                                   {NSRC{w_strb[0]}})) | end_set;
          `DCS_OFF_IMASK: imask <= imask_wr[NSRC-1:0];
          `DCS_OFF_STAT: s_axi_bresp <= `DCS_RESP_OK;
          default: s_axi_bresp <= `DCS_RESP_ERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (!(wr_fire && aw_addr == `DCS_OFF_ACTEN)) begin
        acten <= acten & ~end_clr;
      end
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `DCS_RESP_OK;
        case (s_axi_araddr)
          `DCS_OFF_CTRL: s_axi_rdata <= ctrl;
          `DCS_OFF_VBASE: s_axi_rdata <= vbase;
          `DCS_OFF_ACTEN: s_axi_rdata <= {{(32-NSRC){1'b0}}, acten};
          `DCS_OFF_ISTAT: s_axi_rdata <= {{(32-NSRC){1'b0}}, istat};
          `DCS_OFF_IMASK: s_axi_rdata <= {{(32-NSRC){1'b0}}, imask};
          `DCS_OFF_STAT: s_axi_rdata <= {{(24-SRCW){1'b0}}, src, 4'h0,
                                        (state != S_IDLE), state};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `DCS_RESP_ERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      irq <= |((istat | end_set) & imask);
    end
  end

  // =====================================================
  // transfer sequencer
  // one memory access at a time; mem_req holds until mem_ack
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      src <= {SRCW{1'b0}};
      rec_ptr <= 32'h00000000;
      widx <= 2'h0;
      mode <= 8'h00;
      sar <= 32'h00000000;
      dar <= 32'h00000000;
      transfer_counter_a <= 16'h0000;
      crb <= 16'h0000;
      go_chain <= 1'b0;
      cnt_done <= 1'b0;
      chained <= 1'b0;
      fin_raise <= 1'b0;
      act_clr <= {NSRC{1'b0}};
      spent <= {NSRC{1'b0}};
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_byte <= 1'b0;
      mem_addr <= 32'h00000000;
      mem_wdata <= 32'h00000000;
    end else begin
      act_clr <= {NSRC{1'b0}};
      spent <= spent & req_s2;
      case (state)
        S_IDLE: begin
          chained <= 1'b0;
          if (ctrl[`DCS_CTRL_RUN] && pend != {NSRC{1'b0}}) begin
            src <= lowest(pend);
            state <= S_VEC;
          end
        end
        S_VEC: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_byte <= 1'b0;
            mem_addr <= vbase + {20'h00000, vec_num, 2'b00};
          end else if (mem_ack) begin
            rec_ptr <= mem_rdata;
            mem_addr <= mem_rdata;
            widx <= 2'h0;
            state <= S_REC;
          end
        end
        S_REC: begin
          mem_req <= 1'b1;
          mem_we <= 1'b0;
          mem_byte <= 1'b0;
          if (mem_req && mem_ack) begin
            case (widx)
              2'h0: mode <= mem_rdata[7:0];
              2'h1: sar <= mem_rdata;
              2'h2: dar <= mem_rdata;
              default: {crb, transfer_counter_a} <= mem_rdata;
            endcase
            widx <= widx + 2'h1;
            mem_addr <= mem_addr + 32'h00000004;
            if (widx == `DCS_REC_LAST) begin
              mem_req <= 1'b0;
              state <= S_RD;
            end
          end
        end
        S_RD: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_byte <= 1'b1;
            mem_addr <= sar;
          end else if (mem_ack) begin
            mem_we <= 1'b1;
            mem_addr <= dar;
            mem_wdata <= {24'h000000, mem_rdata[7:0]};
            state <= S_WR;
          end
        end
        S_WR: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            sar <= sar + {31'h00000000, mode[`DCS_MB_SRC_INC]};
            dar <= dar + {31'h00000000, mode[`DCS_MB_DST_INC]};
            transfer_counter_a <= next_cra;
            crb <= next_crb;
            if (xfer_end) begin
              // a block runs to its end within one activation
              go_chain <= next_chain;
              cnt_done <= zero_after;
              widx <= 2'h0;
              state <= S_WB;
            end else begin
              state <= S_RD;
            end
          end
        end
        S_WB: begin
          mem_req <= 1'b1;
          mem_we <= 1'b1;
          mem_byte <= 1'b0;
          mem_addr <= rec_ptr + {28'h0000000, widx, 2'b00};
          case (widx)
            2'h0: mem_wdata <= {24'h000000, mode};
            2'h1: mem_wdata <= sar;
            2'h2: mem_wdata <= dar;
            default: mem_wdata <= {crb, transfer_counter_a};
          endcase
          if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            widx <= widx + 2'h1;
            if (widx == `DCS_REC_LAST) begin
              if (go_chain) begin
                // chaining on keeps the source pending: no irq here
                chained <= 1'b1;
                rec_ptr <= rec_ptr + `DCS_REC_STEP;
                mem_addr <= rec_ptr + `DCS_REC_STEP;
                widx <= 2'h0;
                state <= S_REC;
              end else begin
                fin_raise <= cnt_done | chained | mode[`DCS_MB_INTERRUPT_EACH_TRANSFER_SELECT];
                state <= S_END;
              end
            end
          end
        end
        S_END: begin
          // source flag is consumed unless it is forwarded to the cpu
          if (!fin_raise) begin
            act_clr <= {{(NSRC-1){1'b0}}, 1'b1} << src;
            spent <= spent | ({{(NSRC-1){1'b0}}, 1'b1} << src);
          end
          fin_raise <= 1'b0;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // dcs_chain_seq
`default_nettype wire

// ==== design/dcs_consts.vh ====
// Purpose: shared constants of the chain transfer sequencer
// Assumes: included by dcs_chain_seq.v
// Notes: offsets are byte addresses on the register bus
`ifndef DCS_CONSTS_VH
`define DCS_CONSTS_VH
// =====================================================
// register map
`define DCS_OFF_CTRL 8'h00
`define DCS_OFF_VBASE 8'h04
`define DCS_OFF_ACTEN 8'h08
`define DCS_OFF_ISTAT 8'h0c
`define DCS_OFF_IMASK 8'h10
`define DCS_OFF_STAT 8'h14
`define DCS_CTRL_RUN 0
`define DCS_CTRL_LEGACY 1
`define DCS_CTRL_RST 32'h00000000
`define DCS_VBASE_RST 32'h0000fc00
`define DCS_RESP_OK 2'b00
`define DCS_RESP_ERR 2'b10
// =====================================================
// vector slots: source 0 (timer compare) owns slot 142
`define DCS_VEC_FIRST 10'h08e
// =====================================================
// record layout: word0 mode, word1 source, word2 dest, word3 counters
`define DCS_REC_LAST 2'h3
`define DCS_REC_STEP 32'h00000010
`define DCS_MB_CHAIN_EN 7
`define DCS_MB_CHAIN_SEL 6
`define DCS_MB_INTERRUPT_EACH_TRANSFER_SELECT 5
`define DCS_MB_BLOCK 4
`define DCS_MB_SRC_INC 1
`define DCS_MB_DST_INC 0
`endif

// ==== tb/dcs_seq_sva.sv ====
// Purpose: port assertions of the chain sequencer
// Assumes: bound into dcs_chain_seq
// Notes: memory and register handshakes, byte copy and activation clear
`timescale 1ns/1ns
`default_nettype none
module dcs_seq_sva #(parameter NSRC = 4) (
  input wire ref_clk,
  input wire rst_n,
  input wire [NSRC-1:0] act_clr,
  input wire mem_req,
  input wire mem_we,
  input wire mem_byte,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire [31:0] mem_rdata,
  input wire mem_ack,
  input wire s_axi_awready,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ======================================
  // last byte fetched from the source side
  logic [7:0] last_rd;
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n) last_rd <= 8'h00;
    else if (mem_ack && mem_req && mem_byte && !mem_we) last_rd <= mem_rdata[7:0];
  a_mem_hold: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request moved before ack");
  a_word_align: assert property (
    mem_req && !mem_byte |-> mem_addr[1:0] == 2'b00) else $error("unaligned word");
  a_byte_pair: assert property (
    mem_ack && mem_req && mem_byte && !mem_we |=> ##[0:8] mem_req && mem_we && mem_byte)
    else $error("byte read without write");
  a_byte_copy: assert property (
    mem_req && mem_we && mem_byte |-> mem_wdata[7:0] == last_rd) else $error("byte altered");
  a_clr_pulse: assert property (
    act_clr != 0 |-> $onehot(act_clr) ##1 act_clr == 0) else $error("clear not one pulse");
  a_clr_quiet: assert property (
    act_clr != 0 |=> !$rose(irq)) else $error("irq on consumed activation");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready long");
  a_ar_answer: assert property (s_axi_arready |=> s_axi_rvalid) else $error("read late");
  c_clr: cover property (act_clr != 0);
  c_irq: cover property ($rose(irq));
  c_copy: cover property (mem_ack && mem_we && mem_byte);
endmodule // dcs_seq_sva
bind dcs_chain_seq dcs_seq_sva #(.NSRC(NSRC)) u_dcs_seq_sva (.ref_clk, .rst_n, .act_clr,
  .mem_req, .mem_we, .mem_byte, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
  .s_axi_awready, .s_axi_arready, .s_axi_rvalid, .irq);
`default_nettype wire

// ==== tb/dcs_far_model.sv ====
// Purpose: activation sources and byte memory beside the sequencer
// Assumes: one access at a time, ack after lat waiting cycles
// Notes: read data toggles whenever no answer is due
`timescale 1ns/1ns
`default_nettype none
module dcs_far_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] raise,
  input wire logic [3:0] drop,
  input wire logic [3:0] lat,
  input wire logic [3:0] act_clr,
  output logic [3:0] act_req,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_byte,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  logic [7:0] mem [logic [31:0]];
  logic [3:0] cnt;
  function automatic logic [31:0] rd_word(input logic [31:0] a);
    return {mem[a+3], mem[a+2], mem[a+1], mem[a]};
  endfunction
  task automatic put_word(input logic [31:0] a, input logic [31:0] d);
    for (int i = 0; i < 4; i++) mem[a+32'(i)] = d[8*i+:8];
  endtask
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_req <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      cnt <= 4'h0;
    end else begin
      // a flag stays up until consumed by act_clr or dropped by the cpu
      act_req <= (act_req | raise) & ~drop & ~act_clr;
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && cnt < lat) cnt <= cnt + 4'h1;
      else if (mem_req && !mem_ack) begin
        cnt <= 4'h0;
        mem_ack <= 1'b1;
        if (!mem_we) mem_rdata <= mem_byte ? {24'h0, mem[mem_addr]} : rd_word(mem_addr);
        else if (mem_byte) mem[mem_addr] = mem_wdata[7:0];
        else put_word(mem_addr, mem_wdata);
      end
    end
  end
endmodule // dcs_far_model
`default_nettype wire

// ==== tb/test_dtc_chain_transfer_sequencer.sv ====
// Purpose: self-checking bench of the chain sequencer
// Assumes: far model holds records, vectors and data
// Notes: registers reached over AXI4-Lite
`timescale 1ns/1ns
`default_nettype none
`include "dcs_consts.vh"
module test_dtc_chain_transfer_sequencer;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] raise = 4'h0, drop = 4'h0, lat = 4'h0, act_req, act_clr;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, mem_addr, mem_wdata, mem_rdata, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic mem_req, mem_we, mem_byte, mem_ack, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, wrsp;
  int fail_count = 0;
  int n_compared = 0;
  always #4 ref_clk = ~ref_clk;
  dcs_chain_seq #(.NSRC(4), .SRCW(2)) u_dcs_chain_seq (.ref_clk, .rst_n, .act_req, .act_clr,
    .mem_req, .mem_we, .mem_byte, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
  dcs_far_model u_dcs_far_model (.ref_clk, .rst_n, .raise, .drop, .lat, .act_clr, .act_req,
    .mem_req, .mem_we, .mem_byte, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
  // ======================================
  // shared tasks
  task automatic complete_run;
    if (fail_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] init(input logic [31:0] a);
    return {24'h0, a[7:0] ^ 8'h5a};
  endfunction
  function automatic logic [31:0] mb(input logic [31:0] a);
    return {24'h0, u_dcs_far_model.mem[a]};
  endfunction
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    wrsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 50) fail_count++;
  endtask
  task automatic rd_is(input logic [7:0] a, input logic [31:0] exp);
    int n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    check(rd, exp);
    if (n == 50) fail_count++;
  endtask
  task automatic irq_is(input logic e);
    repeat (3) @(posedge ref_clk);
    check({31'h0, irq}, {31'h0, e});
  endtask
  task automatic rec(input logic [31:0] a, m, s, d, c);
    u_dcs_far_model.put_word(a, m);
    u_dcs_far_model.put_word(a + 4, s);
    u_dcs_far_model.put_word(a + 8, d);
    u_dcs_far_model.put_word(a + 12, c);
  endtask
  task automatic run_act(input int s, input logic e);
    int n = 0;
    logic clr = 1'b0;
    @(posedge ref_clk);
    raise[s] <= 1'b1;
    @(posedge ref_clk);
    raise[s] <= 1'b0;
    while (!irq && !clr && n < 3000) begin
      @(posedge ref_clk);
      n++;
      clr = act_clr[s];
    end
    // the cpu side takes the source flag down once it has seen the end
    drop[s] <= 1'b1;
    @(posedge ref_clk);
    drop[s] <= 1'b0;
    check({31'h0, irq}, {31'h0, e});
    check({31'h0, clr}, {31'h0, !e});
  endtask
  // ======================================
  // scenarios
  task automatic regs_reset;
    rd_is(`DCS_OFF_VBASE, `DCS_VBASE_RST);
    rd_is(8'h20, 32'h0);
    check({30'h0, rsp}, {30'h0, `DCS_RESP_ERR});
    s_axi_wstrb <= 4'h2;
    axi_wr(`DCS_OFF_VBASE, 32'hffffffff);
    s_axi_wstrb <= 4'hf;
    rd_is(`DCS_OFF_VBASE, 32'h0000ff00);
    axi_wr(8'h20, 32'h0);
    check({30'h0, wrsp}, {30'h0, `DCS_RESP_ERR});
    for (int i = 0; i < 128; i++) u_dcs_far_model.mem[32'h1000 + i] = init(32'h1000 + i);
    axi_wr(`DCS_OFF_IMASK, 32'hf);
    axi_wr(`DCS_OFF_ACTEN, 32'hf);
    axi_wr(`DCS_OFF_CTRL, 32'h1);
    check({30'h0, wrsp}, {30'h0, `DCS_RESP_OK});
  endtask
  task automatic chain_doc;
    axi_wr(`DCS_OFF_VBASE, 32'h0000fc00);
    u_dcs_far_model.put_word(32'h0000fe38, 32'h0000fbe8);
    rec(32'h0000fbe8, 32'hc3, 32'h1000, 32'h1010, 32'h1);
    rec(32'h0000fbf8, 32'h13, 32'h1010, 32'h1020, 32'h00011010);
    run_act(0, 1'b1);
    check(u_dcs_far_model.rd_word(32'hfbf4), 32'h0);
    check(u_dcs_far_model.rd_word(32'hfbec), 32'h1001);
    check(mb(32'h1020), init(32'h1000));
    for (int i = 1; i < 16; i++) check(mb(32'h1020 + i), init(32'h1010 + i));
    check(mb(32'h1030), init(32'h1030));
    rd_is(`DCS_OFF_ACTEN, 32'he);
    axi_wr(`DCS_OFF_IMASK, 32'h0);
    irq_is(1'b0);
    axi_wr(`DCS_OFF_IMASK, 32'hf);
    irq_is(1'b1);
    axi_wr(`DCS_OFF_ISTAT, 32'h1);
    irq_is(1'b0);
  endtask
  task automatic chain_unmet;
    lat <= 4'h3;
    axi_wr(`DCS_OFF_VBASE, 32'h00002000);
    u_dcs_far_model.put_word(32'h0000223c, 32'h3000);
    rec(32'h3000, 32'hc3, 32'h1000, 32'h1040, 32'h3);
    rec(32'h3010, 32'h03, 32'h1000, 32'h1050, 32'h1);
    run_act(1, 1'b0);
    check(u_dcs_far_model.rd_word(32'h300c), 32'h2);
    check(mb(32'h1040), init(32'h1000));
    check(mb(32'h1050), init(32'h1050));
    rd_is(`DCS_OFF_ACTEN, 32'he);
  endtask
  task automatic chain_free;
    lat <= 4'h1;
    u_dcs_far_model.put_word(32'h00002240, 32'h3100);
    rec(32'h3100, 32'ha3, 32'h1001, 32'h1060, 32'h3);
    rec(32'h3110, 32'h03, 32'h1002, 32'h1070, 32'h2);
    run_act(2, 1'b1);
    check(mb(32'h1060), init(32'h1001));
    check(mb(32'h1070), init(32'h1002));
    check(u_dcs_far_model.rd_word(32'h311c), 32'h1);
    axi_wr(`DCS_OFF_ISTAT, 32'h4);
    irq_is(1'b0);
  endtask
  // block record with chain-select: legacy needs the block count at zero, else block end
  task automatic chain_legacy;
    axi_wr(`DCS_OFF_CTRL, 32'h3);
    u_dcs_far_model.put_word(32'h00002244, 32'h3200);
    rec(32'h3200, 32'hd3, 32'h1004, 32'h1078, 32'h00020202);
    rec(32'h3210, 32'h03, 32'h1006, 32'h107c, 32'h1);
    run_act(3, 1'b0);
    check(u_dcs_far_model.rd_word(32'h320c), 32'h00010202);
    check(mb(32'h1079), init(32'h1005));
    check(mb(32'h107c), init(32'h107c));
    axi_wr(`DCS_OFF_CTRL, 32'h1);
    run_act(3, 1'b1);
    check(mb(32'h107b), init(32'h1007));
    check(mb(32'h107c), init(32'h1006));
    check(u_dcs_far_model.rd_word(32'h320c), 32'h00000202);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    regs_reset();
    chain_doc();
    chain_unmet();
    chain_free();
    chain_legacy();
    complete_run();
  end
  initial begin
    #400000;
    fail_count++;
    complete_run();
  end
endmodule // test_dtc_chain_transfer_sequencer
`default_nettype wire
